// [inc/sesr_pkg.sv]
// sesr_pkg: offsets, field positions and reset values of the socket
// change register bank.
// assumes a dword-aligned register port with a byte offset address.
package sesr_pkg;

    // register offsets, byte addresses
    localparam int unsigned REG_AW = 8;
    localparam logic [7:0] OFF_CHANGE_LATCH = 8'h00;
    localparam logic [7:0] OFF_CHANGE_GATE = 8'h04;
    localparam logic [7:0] OFF_LIVE_CONDITION = 8'h08;
    localparam logic [7:0] OFF_CHANGE_INJECT = 8'h0c;
    localparam logic [7:0] OFF_SETUP = 8'h10;
    localparam logic [7:0] OFF_RSVD_FIRST = 8'h14;
    localparam logic [7:0] OFF_RSVD_LAST = 8'h1c;
    localparam logic [7:0] OFF_POWER_MANAGE = 8'h20;

    // event, mask and present-state field positions
    localparam int unsigned EVENT_BITS = 4;
    localparam int unsigned BIT_STATUS = 0;
    localparam int unsigned BIT_CD_ONE = 1;
    localparam int unsigned BIT_CD_TWO = 2;
    localparam int unsigned BIT_POWER = 3;

    // socket setup and power management fields
    localparam int unsigned SETUP_W = 8;
    localparam int unsigned SETUP_IRQ_EN_BIT = 0;
    localparam int unsigned PM_PME_EN_BIT = 0;

    // reset values
    localparam logic [3:0] EVENT_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic PME_EN_RST = 1'b0;
    localparam logic [31:0] LIVE_FIXED = 32'h3000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // synchroniser input lanes
    localparam int unsigned SYNC_W = 5;
    localparam int unsigned LANE_BUS_RST = 4;

endpackage : sesr_pkg

// [logic/sesr_regs.sv]
// sesr_regs: socket change register bank with event latch, mask,
// present state, force event, setup and power management registers.
// assumes a simple dword register port on i_clk and socket pins that
// arrive asynchronously; i_rst_n is the global reset.
`timescale 1ns/1ps
module sesr_regs (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pci_bus_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [3:0] i_reg_be,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_status_pin,
    input wire logic i_card_detect_one,
    input wire logic i_card_detect_two,
    input wire logic i_power_cycle_state,
    input wire logic i_card_is_cardbus,
    input wire logic i_pc_card_reset,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_change_irq,
    output logic o_pme_enable,
    output logic [7:0] o_socket_setup
);

    localparam int unsigned EB = sesr_pkg::EVENT_BITS;

    // refuse package values that the fixed lane-0 layout cannot serve
    if (EB != 4) begin : g_chk_eb
        $error("sesr_regs: EVENT_BITS must be 4");
    end
    if (sesr_pkg::SYNC_W != EB + 1) begin : g_chk_sync
        $error("sesr_regs: SYNC_W must be EVENT_BITS plus one");
    end
    if (sesr_pkg::LANE_BUS_RST != EB) begin : g_chk_lane
        $error("sesr_regs: bus reset lane must follow the pin lanes");
    end
    if (sesr_pkg::BIT_POWER >= EB) begin : g_chk_pos
        $error("sesr_regs: event field position beyond event width");
    end
    if (sesr_pkg::SETUP_W != 8) begin : g_chk_setup
        $error("sesr_regs: setup field must fill byte lane 0");
    end
    if (sesr_pkg::SETUP_IRQ_EN_BIT >= sesr_pkg::SETUP_W) begin : g_chk_irq
        $error("sesr_regs: interrupt enable outside setup field");
    end
    if (sesr_pkg::PM_PME_EN_BIT > 7) begin : g_chk_pm
        $error("sesr_regs: power event enable outside byte lane 0");
    end
    if (sesr_pkg::REG_AW != 8) begin : g_chk_aw
        $error("sesr_regs: register address port is 8 bits");
    end
    if (sesr_pkg::OFF_RSVD_FIRST > sesr_pkg::OFF_RSVD_LAST) begin : g_chk_rsvd
        $error("sesr_regs: reserved window bounds out of order");
    end

    // synchronised pins
    logic [sesr_pkg::SYNC_W-1:0] pin_s;
    logic [EB-1:0] live;
    logic bus_rst;

    // held state
    logic [EB-1:0] prev_r;
    logic pcr_r;
    logic [EB-1:0] event_r;
    logic [EB-1:0] event_nxt;
    logic [EB-1:0] mask_r;
    logic [7:0] setup_r;
    logic pme_en_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic rvalid_r;
    logic irq_r;
    logic irq_nxt;

    // decode
    logic hit_latch;
    logic hit_gate;
    logic hit_live;
    logic hit_inject;
    logic hit_setup;
    logic hit_pm;
    logic hit_rsvd;
    logic lane0_wr;

    // event sources
    logic [EB-1:0] change;
    logic status_rise;
    logic status_set;
    logic leave_reset;
    logic [EB-1:0] hw_set;
    logic [EB-1:0] sw_set;
    logic [EB-1:0] sw_clr;
    logic ctx_clear;

    //------------------------------------------------------------------
    // pin synchronisation
    //------------------------------------------------------------------
    sesr_sync #(
        .WIDTH(sesr_pkg::SYNC_W)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({!i_pci_bus_reset_n,
                  i_power_cycle_state,
                  i_card_detect_two,
                  i_card_detect_one,
                  i_status_pin}),
        .o_sync(pin_s)
    );

    assign live = pin_s[EB-1:0];
    assign bus_rst = pin_s[sesr_pkg::LANE_BUS_RST];

    // context bits survive a bus reset while power events are enabled
    assign ctx_clear = bus_rst && !pme_en_r;

    //------------------------------------------------------------------
    // address decode, dword granular
    //------------------------------------------------------------------
    assign hit_latch =
        i_reg_addr[7:2] == sesr_pkg::OFF_CHANGE_LATCH[7:2];
    assign hit_gate =
        i_reg_addr[7:2] == sesr_pkg::OFF_CHANGE_GATE[7:2];
    assign hit_live =
        i_reg_addr[7:2] == sesr_pkg::OFF_LIVE_CONDITION[7:2];
    assign hit_inject =
        i_reg_addr[7:2] == sesr_pkg::OFF_CHANGE_INJECT[7:2];
    assign hit_setup =
        i_reg_addr[7:2] == sesr_pkg::OFF_SETUP[7:2];
    assign hit_pm =
        i_reg_addr[7:2] == sesr_pkg::OFF_POWER_MANAGE[7:2];

    // reserved window decodes only to read zero and swallow writes
    assign hit_rsvd =
        (i_reg_addr[7:2] >= sesr_pkg::OFF_RSVD_FIRST[7:2]) &&
        (i_reg_addr[7:2] <= sesr_pkg::OFF_RSVD_LAST[7:2]);

    // every writable field lives in byte lane 0
    assign lane0_wr = i_reg_wr && i_reg_be[0];

    //------------------------------------------------------------------
    // change detection
    //------------------------------------------------------------------
    // prev_r starts at zero: a card seated during reset shows up as a
    // change once the synchroniser has filled
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_r <= sesr_pkg::EVENT_RST;
        end else begin
            prev_r <= live;
        end
    end

    // card reset comes from i_clk logic, so it skips the synchroniser
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pcr_r <= 1'b0;
        end else begin
            pcr_r <= i_pc_card_reset;
        end
    end

    // only that a change occurred is kept, never the new level
    assign change = live ^ prev_r;
    assign status_rise =
        live[sesr_pkg::BIT_STATUS] && !prev_r[sesr_pkg::BIT_STATUS];

    // cardbus cards flag rising edges, 16-bit cards both edges
    assign status_set = i_card_is_cardbus ? status_rise
                                          : change[sesr_pkg::BIT_STATUS];

    // falling edge of card reset: status or card detect still present re-flags, power does not
    assign leave_reset = pcr_r && !i_pc_card_reset;

    always_comb begin
        hw_set = '0;
        hw_set[sesr_pkg::BIT_STATUS] = status_set ||
            (leave_reset && live[sesr_pkg::BIT_STATUS]);
        hw_set[sesr_pkg::BIT_CD_ONE] = change[sesr_pkg::BIT_CD_ONE] ||
            (leave_reset && live[sesr_pkg::BIT_CD_ONE]);
        hw_set[sesr_pkg::BIT_CD_TWO] = change[sesr_pkg::BIT_CD_TWO] ||
            (leave_reset && live[sesr_pkg::BIT_CD_TWO]);
        hw_set[sesr_pkg::BIT_POWER] = change[sesr_pkg::BIT_POWER];
    end

    // force register acts just like a socket change
    assign sw_set = (lane0_wr && hit_inject) ? i_reg_wdata[EB-1:0]
                                             : '0;
    assign sw_clr = (lane0_wr && hit_latch) ? i_reg_wdata[EB-1:0]
                                            : '0;

    //------------------------------------------------------------------
    // event latch
    //------------------------------------------------------------------
    for (genvar i = 0; i < EB; i++) begin : g_event
        // mask plays no part in setting
        always_comb begin
            if (ctx_clear) begin
                event_nxt[i] = 1'b0;
            end else if (hw_set[i] || sw_set[i]) begin
                event_nxt[i] = 1'b1;
            end else if (sw_clr[i]) begin
                event_nxt[i] = 1'b0;
            end else begin
                event_nxt[i] = event_r[i];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            event_r <= sesr_pkg::EVENT_RST;
        end else begin
            event_r <= event_nxt;
        end
    end

    //------------------------------------------------------------------
    // mask register, a context register like the latch
    //------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_r <= sesr_pkg::MASK_RST;
        end else if (ctx_clear) begin
            mask_r <= sesr_pkg::MASK_RST;
        end else if (lane0_wr && hit_gate) begin
            mask_r <= i_reg_wdata[EB-1:0];
        end
    end

    //------------------------------------------------------------------
    // socket setup register
    //------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            setup_r <= sesr_pkg::SETUP_RST;
        end else if (ctx_clear) begin
            setup_r <= sesr_pkg::SETUP_RST;
        end else if (lane0_wr && hit_setup) begin
            setup_r <= i_reg_wdata[sesr_pkg::SETUP_W-1:0];
        end
    end

    //------------------------------------------------------------------
    // power management register, global reset only
    //------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pme_en_r <= sesr_pkg::PME_EN_RST;
        end else if (lane0_wr && hit_pm) begin
            pme_en_r <= i_reg_wdata[sesr_pkg::PM_PME_EN_BIT];
        end
    end

    //------------------------------------------------------------------
    // status change interrupt
    //------------------------------------------------------------------
    // stale bits fire as soon as interrupts are enabled; clearing
    // them first is up to software
    always_comb begin
        irq_nxt = setup_r[sesr_pkg::SETUP_IRQ_EN_BIT] &&
                  |(event_r & mask_r);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    //------------------------------------------------------------------
    // read path, one cycle latency
    //------------------------------------------------------------------
    always_comb begin
        rdata_nxt = sesr_pkg::READ_ZERO;
        if (hit_latch) begin
            rdata_nxt[EB-1:0] = event_r;
        end else if (hit_gate) begin
            rdata_nxt[EB-1:0] = mask_r;
        end else if (hit_live) begin
            rdata_nxt = sesr_pkg::LIVE_FIXED;
            rdata_nxt[EB-1:0] = live;
        end else if (hit_setup) begin
            rdata_nxt[sesr_pkg::SETUP_W-1:0] = setup_r;
        end else if (hit_pm) begin
            rdata_nxt[sesr_pkg::PM_PME_EN_BIT] = pme_en_r;
        end else if (hit_rsvd) begin
            rdata_nxt = sesr_pkg::READ_ZERO;
        end
        // force event is write-only, unmapped offsets read zero
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= sesr_pkg::READ_ZERO;
        end else if (i_reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= i_reg_rd;
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_change_irq = irq_r;
    assign o_pme_enable = pme_en_r;
    assign o_socket_setup = setup_r;

endmodule : sesr_regs

// [logic/sesr_sync.sv]
// sesr_sync: three-flop synchroniser per lane, output moves only once
// the second and third stage agree.
// assumes inputs come from pins outside the i_clk domain.
`timescale 1ns/1ps
module sesr_sync #(
    parameter int unsigned WIDTH = 5
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    if (WIDTH < 1) begin : g_chk
        $error("sesr_sync: WIDTH must be at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic out_r;

        // first stage feeds only the second
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
                s3_r <= 1'b0;
            end else begin
                s1_r <= i_async[i];
                s2_r <= s1_r;
                s3_r <= s2_r;
            end
        end

        // filters a single-cycle glitch out of stage two
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                out_r <= 1'b0;
            end else if (s2_r == s3_r) begin
                out_r <= s3_r;
            end
        end

        assign o_sync[i] = out_r;
    end

endmodule : sesr_sync

// [testbench/sesr_card_model.sv]
// sesr_card_model: card in the socket, drives its sense pins.
// assumes the bench commands each pin change through set_pins.
`timescale 1ns/1ps
module sesr_card_model (
    input wire logic i_clk,
    output logic o_status_pin,
    output logic o_card_detect_one,
    output logic o_card_detect_two,
    output logic o_power_cycle_state,
    output logic o_card_is_cardbus
);
    initial begin
        {o_power_cycle_state, o_card_detect_two, o_card_detect_one} = 3'h0;
        {o_status_pin, o_card_is_cardbus} = 2'h0;
    end
    // pins move just after an edge; the design resyncs all of them but the cardbus flag
    task automatic set_pins(input logic [3:0] p, input logic cb);
        @(posedge i_clk);
        {o_power_cycle_state, o_card_detect_two} <= p[3:2];
        {o_card_detect_one, o_status_pin} <= p[1:0];
        o_card_is_cardbus <= cb;
    endtask : set_pins
endmodule : sesr_card_model

// [testbench/sesr_regs_props.sv]
// sesr_regs_props: port checks for the socket change register bank.
// assumes it is bound to sesr_regs and sees only its ports.
`timescale 1ns/1ps
module sesr_regs_props (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pci_bus_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [3:0] i_reg_be,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [31:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_change_irq,
    input wire logic o_pme_enable,
    input wire logic [7:0] o_socket_setup
);
    logic [5:0] wa;
    logic [3:0] quiet_r;
    assign wa = i_reg_addr[7:2];
    // bus reset pin is synced slowly, trust writes only well after it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            quiet_r <= 4'h0;
        else if (!i_pci_bus_reset_n)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence force_s;
        i_reg_wr && i_reg_be[0] && wa == 6'h03 && quiet_r[3];
    endsequence
    sequence rd_ev_s;
        i_reg_rd && wa == 6'h00;
    endsequence
    rvalid_pulse_a: assert property (
        o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid not one cycle after read");
    read_zero_a: assert property (
        i_reg_rd && wa inside {6'h03, 6'h05, 6'h06, 6'h07}
        |=> o_reg_rdata == 32'h0000_0000) else $error("reserved not 0");
    event_rsvd_a: assert property (
        rd_ev_s |=> o_reg_rdata[31:4] == 28'h000_0000)
        else $error("event upper bits not 0");
    live_fixed_a: assert property (
        i_reg_rd && wa == 6'h02 |=> o_reg_rdata[31:4] == 28'h300_0000)
        else $error("present state fixed bits wrong");
    force_set_a: assert property (
        force_s ##2 rd_ev_s |=> (o_reg_rdata[3:0] &
        $past(i_reg_wdata[3:0], 3)) == $past(i_reg_wdata[3:0], 3))
        else $error("forced event bit not set");
    irq_gate_a: assert property (!o_socket_setup[0] |=> !o_change_irq)
        else $error("irq while disabled");
    setup_write_a: assert property (
        i_reg_wr && i_reg_be[0] && wa == 6'h04 && quiet_r[3]
        |=> o_socket_setup == $past(i_reg_wdata[7:0]))
        else $error("setup write lost");
    bus_clear_a: assert property (
        (!i_pci_bus_reset_n && !o_pme_enable) [*8]
        |-> o_socket_setup == 8'h00) else $error("bus reset kept setup");
    pme_keep_a: assert property (
        o_pme_enable && !i_reg_wr |=> $stable(o_socket_setup))
        else $error("setup lost with power event on");
    pme_only_a: assert property (
        !(i_reg_wr && i_reg_be[0] && wa == 6'h08) |=> $stable(o_pme_enable))
        else $error("power event enable moved");
endmodule : sesr_regs_props
bind sesr_regs sesr_regs_props sesr_regs_props_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_pci_bus_reset_n(i_pci_bus_reset_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_be(i_reg_be),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_change_irq(o_change_irq),
    .o_pme_enable(o_pme_enable), .o_socket_setup(o_socket_setup));

// [testbench/test_socket_event_status_regs.sv]
// test_socket_event_status_regs: self-checking bench for sesr_regs.
// assumes sesr_card_model on the pins and the bound checker.
`timescale 1ns/1ps
module test_socket_event_status_regs;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic bus_n = 1'b1, wr = 1'b0, rd = 1'b0, crst = 1'b0;
    logic [7:0] addr = 8'h00, s, setup;
    logic [3:0] be = 4'h0, b, f, m, np, pins, ev;
    logic [31:0] wdata = 32'h0000_0000, d, rdata;
    logic rvalid, irq, pme, sp, c1, c2, pw, cb, c;
    logic [7:0] ra [10] = '{8'h08, 8'h00, 8'h04, 8'h0c, 8'h10, 8'h14,
        8'h18, 8'h1c, 8'h20, 8'h40};
    int n_fail = 0, checked = 0;
    always #12.5 i_clk = ~i_clk;
    sesr_card_model sesr_card_model_inst (.i_clk(i_clk), .o_status_pin(sp),
        .o_card_detect_one(c1), .o_card_detect_two(c2),
        .o_power_cycle_state(pw), .o_card_is_cardbus(cb));
    sesr_regs sesr_regs_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_pci_bus_reset_n(bus_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_be(be), .i_reg_wdata(wdata),
        .i_status_pin(sp), .i_card_detect_one(c1), .i_card_detect_two(c2),
        .i_power_cycle_state(pw), .i_card_is_cardbus(cb),
        .i_pc_card_reset(crst), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .o_change_irq(irq), .o_pme_enable(pme), .o_socket_setup(setup));
    // cardbus cards flag only the rising status edge
    function automatic logic [3:0] pin_ev(logic [3:0] o, logic [3:0] n,
        logic k);
        pin_ev = o ^ n;
        if (k && !n[0]) pin_ev[0] = 1'b0;
    endfunction : pin_ev
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask : chk1
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v,
        input logic [3:0] e);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        be <= e;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk1(rvalid, 1'b1);
        chk32(rdata, exp);
    endtask : rd_chk
    task automatic results;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // whole run is under a thousand cycles; this is ample margin
    initial begin
        #1_000_000;
        n_fail++;
        results();
    end
    initial begin
        void'($urandom(32'h7c23_5226));
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (10) @(posedge i_clk);
        wr_reg(8'h08, 32'hffff_ffff, 4'hf);
        wr_reg(8'h14, 32'hffff_ffff, 4'hf);
        foreach (ra[i]) rd_chk(ra[i], ra[i] == 8'h08 ?
            sesr_pkg::LIVE_FIXED : 32'h0000_0000);
        $display("test reset map done");
        ev = 4'h0;
        for (int i = 0; i < 24; i++) begin
            d = $urandom;
            b = 4'($urandom);
            wr_reg(8'h0c, d, b);
            if (b[0]) ev |= d[3:0];
            rd_chk(8'h00, {28'h000_0000, ev});
            d = $urandom;
            b = 4'($urandom);
            wr_reg(8'h00, d, b);
            if (b[0]) ev &= ~d[3:0];
            rd_chk(8'h00, {28'h000_0000, ev});
        end
        wr_reg(8'h00, 32'h0000_000f, 4'h1);
        $display("test force and clear done");
        pins = 4'h0;
        for (int i = 0; i < 16; i++) begin
            np = i < 4 ? {3'h0, !i[0]} : 4'($urandom);
            c = i < 4 ? i < 2 : 1'($urandom);
            sesr_card_model_inst.set_pins(np, c);
            repeat (8) @(posedge i_clk);
            rd_chk(8'h08, sesr_pkg::LIVE_FIXED | {28'h000_0000, np});
            ev = pin_ev(pins, np, c);
            rd_chk(8'h00, {28'h000_0000, ev});
            wr_reg(8'h00, 32'h0000_000f, 4'h1);
            pins = np;
        end
        // power change lands in the same cycle as its write-one-to-clear
        np = pins ^ 4'h8;
        sesr_card_model_inst.set_pins(np, 1'b0);
        repeat (3) @(posedge i_clk);
        wr_reg(8'h00, 32'h0000_0008, 4'h1);
        rd_chk(8'h00, 32'h0000_0008);
        pins = np;
        $display("test pin changes done");
        sesr_card_model_inst.set_pins(4'h7, 1'b0);
        repeat (8) @(posedge i_clk);
        wr_reg(8'h00, 32'h0000_000f, 4'h1);
        @(posedge i_clk);
        crst <= 1'b1;
        repeat (3) @(posedge i_clk);
        crst <= 1'b0;
        repeat (3) @(posedge i_clk);
        rd_chk(8'h00, 32'h0000_0007);
        wr_reg(8'h00, 32'h0000_000f, 4'h1);
        $display("test card reset done");
        for (int i = 0; i < 8; i++) begin
            m = 4'($urandom);
            f = 4'($urandom);
            s = 8'($urandom) | 8'h01;
            wr_reg(8'h04, {28'h000_0000, m}, 4'h1);
            wr_reg(8'h0c, {28'h000_0000, f}, 4'h1);
            repeat (3) @(posedge i_clk);
            #1;
            chk1(irq, 1'b0);
            wr_reg(8'h10, {24'h00_0000, s}, 4'h1);
            repeat (3) @(posedge i_clk);
            #1;
            chk1(irq, |(f & m));
            chk32({24'h00_0000, setup}, {24'h00_0000, s});
            rd_chk(8'h10, {24'h00_0000, s});
            wr_reg(8'h10, 32'h0000_0000, 4'h1);
            wr_reg(8'h00, 32'h0000_000f, 4'h1);
        end
        $display("test interrupt done");
        for (int p = 0; p < 2; p++) begin
            wr_reg(8'h20, p ? 32'hffff_ffff : 32'h0000_0000, 4'h1);
            wr_reg(8'h04, 32'h0000_000a, 4'h1);
            wr_reg(8'h10, 32'h0000_00a4, 4'h1);
            wr_reg(8'h0c, 32'h0000_000f, 4'h1);
            @(posedge i_clk);
            bus_n <= 1'b0;
            repeat (8) @(posedge i_clk);
            bus_n <= 1'b1;
            repeat (10) @(posedge i_clk);
            rd_chk(8'h00, p ? 32'h0000_000f : 32'h0000_0000);
            rd_chk(8'h04, p ? 32'h0000_000a : 32'h0000_0000);
            rd_chk(8'h10, p ? 32'h0000_00a4 : 32'h0000_0000);
            rd_chk(8'h20, {31'h0000_0000, p[0]});
            chk1(pme, p[0]);
            chk32({24'h00_0000, setup},
                {24'h00_0000, p ? 8'ha4 : 8'h00});
        end
        $display("test bus reset done");
        results();
    end
endmodule : test_socket_event_status_regs
